// [dsm_top.sv]
`timescale 1ns/100ps
`include "dsm_consts.svh"
// What this block does
// - Output is the selected carrier gated by the modulator, driven to the pin.
// - Modulator high mixes the high carrier; modulator low mixes the low carrier.
// - When disabled, carriers are forced to ground and modulator to software bit.
// - Disabling keeps the stored selections; they apply again when re-enabled.
// - While disabled the output pin stays low.
// - Four-bit field picks the modulator from sixteen sources.
// - Each carrier picked by its own four-bit field from pins, clocks, peripherals.
// - Leaving a synced carrier: other carrier now, synced one until its fall.
// - Returning to a synced carrier: other off now, synced one after its fall.
// - Separate sync enables for high and low carriers.
// - Separate invert bits for the selected high and low carriers.
// - Software bit is the modulator when selected as the source.
// - Output invert bit inverts the output only while enabled; idle output stays low.
// - Modulation keeps running in sleep while sources keep running.
// - Reset disables the block and restores register defaults.
// - Read-only status bit shows the current output level.
// - Enable at control bit 7, software bit at bit 0.
// - Modulator code 0 is software bit, 1 is the pin, rest peripherals.
// - Carrier code 9 is unconnected, code 0 is ground.
// - Carrier invert at bit 6, sync enable at bit 5.
module dsm_top
    import dsm_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Source signals, index equals select code
    input  wire logic        mod_input_pin_i,
    input  wire logic [15:2] mod_periph_i,
    input  wire logic        carrier_input_pin_a_i,
    input  wire logic        carrier_input_pin_b_i,
    input  wire logic [15:3] car_periph_i,
    // Modulated output pin
    output logic             mod_out_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic        enable_q;
    logic        out_inv_q;
    logic        sw_bit_q;
    dsm_code_t   mod_sel_q;
    dsm_code_t   hi_sel_q;
    logic        hi_inv_q;
    logic        hi_sync_q;
    dsm_code_t   lo_sel_q;
    logic        lo_inv_q;
    logic        lo_sync_q;
    logic        out_q;

    logic        access;
    logic        wr_en;
    logic        mapped;
    logic [31:0] rd_data;
    logic        wr_ctrl;
    logic        wr_src;
    logic        wr_carrier_high;
    logic        wr_carrier_low;
    logic [7:0]  ctrl_img;
    logic [7:0]  src_img;
    logic [7:0]  carrier_high_img;
    logic [7:0]  carrier_low_img;

    // Reset image kept as a typed constant so single bits can be picked out
    localparam dsm_byte_t CTRL_RESET = `DSM_CTRL_RESET;

    ////////////////////////////////////////////////////////////////////////////
    // APB: one wait state, pready from a flop
    assign access = psel_i & penable_i;
    assign wr_en  = access & pready_o & pwrite_i;

    // One strobe per register keeps each register's process to its own concern
    assign wr_ctrl = wr_en & (paddr_i == `DSM_ADDR_CTRL);
    assign wr_src  = wr_en & (paddr_i == `DSM_ADDR_SRC);
    assign wr_carrier_high = wr_en & (paddr_i == `DSM_ADDR_CARRIER_HIGH);
    assign wr_carrier_low = wr_en & (paddr_i == `DSM_ADDR_CARRIER_LOW);

    // Read images; unimplemented bits are tied low here and never stored
    assign ctrl_img = {enable_q, 2'b00, out_inv_q, out_q, 2'b00, sw_bit_q};
    assign src_img  = {4'h0, mod_sel_q};
    assign carrier_high_img = {1'b0, hi_inv_q, hi_sync_q, 1'b0, hi_sel_q};
    assign carrier_low_img = {1'b0, lo_inv_q, lo_sync_q, 1'b0, lo_sel_q};

    always_comb begin
        mapped = 1'b1;
        case (paddr_i)
            `DSM_ADDR_CTRL: begin
                rd_data = {24'h000000, ctrl_img};
            end
            `DSM_ADDR_SRC: begin
                rd_data = {24'h000000, src_img};
            end
            `DSM_ADDR_CARRIER_HIGH: begin
                rd_data = {24'h000000, carrier_high_img};
            end
            `DSM_ADDR_CARRIER_LOW: begin
                rd_data = {24'h000000, carrier_low_img};
            end
            default: begin
                rd_data = 32'h00000000;
                mapped  = 1'b0;
            end
        endcase
    end

    // Ready in the second access cycle: exactly one wait state per transfer
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= access & ~pready_o;
        end
    end

    // Error rides on the same edge as ready, only for unmapped addresses
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= access & ~pready_o & ~mapped;
        end
    end

    // Read data held until the next read, so a late sample still sees it
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= 32'h00000000;
        end else if (access & ~pready_o & ~pwrite_i) begin
            prdata_o <= rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register bank, one process per register; writes land on the edge that ends the ready cycle
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            enable_q  <= CTRL_RESET[`DSM_CTRL_EN_BIT];
            out_inv_q <= CTRL_RESET[`DSM_CTRL_OINV_BIT];
            sw_bit_q  <= CTRL_RESET[`DSM_CTRL_SWBIT_BIT];
        end else if (wr_ctrl) begin
            enable_q  <= pwdata_i[`DSM_CTRL_EN_BIT];
            out_inv_q <= pwdata_i[`DSM_CTRL_OINV_BIT];
            sw_bit_q  <= pwdata_i[`DSM_CTRL_SWBIT_BIT];
        end
    end

    // Selections change only through their own registers, never on disable
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mod_sel_q <= `DSM_SRC_RESET;
        end else if (wr_src) begin
            mod_sel_q <= pwdata_i[`DSM_FIELD_MSB:0];
        end
    end

    // High and low carrier registers share one layout
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            hi_sel_q  <= `DSM_CAR_RESET;
            hi_inv_q  <= 1'b0;
            hi_sync_q <= 1'b0;
        end else if (wr_carrier_high) begin
            hi_inv_q  <= pwdata_i[`DSM_CAR_INV_BIT];
            hi_sync_q <= pwdata_i[`DSM_CAR_SYNC_BIT];
            hi_sel_q  <= pwdata_i[`DSM_FIELD_MSB:0];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            lo_sel_q  <= `DSM_CAR_RESET;
            lo_inv_q  <= 1'b0;
            lo_sync_q <= 1'b0;
        end else if (wr_carrier_low) begin
            lo_inv_q  <= pwdata_i[`DSM_CAR_INV_BIT];
            lo_sync_q <= pwdata_i[`DSM_CAR_SYNC_BIT];
            lo_sel_q  <= pwdata_i[`DSM_FIELD_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source synchronisers; sources are asynchronous to mclk_i
    logic [15:2] mod_periph_s;
    logic [15:3] car_periph_s;
    logic [2:0]  pins_s;

    dsm_sync2 #(.WIDTH(14)) u_sync_mod (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .async_i (mod_periph_i),
        .sync_o  (mod_periph_s)
    );

    dsm_sync2 #(.WIDTH(13)) u_sync_car (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .async_i (car_periph_i),
        .sync_o  (car_periph_s)
    );

    dsm_sync2 #(.WIDTH(3)) u_sync_pin (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .async_i ({carrier_input_pin_b_i, carrier_input_pin_a_i, mod_input_pin_i}),
        .sync_o  (pins_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Effective selections: disable overrides without touching stored values
    dsm_code_t   mod_eff;
    dsm_code_t   hi_eff;
    dsm_code_t   lo_eff;
    logic        modulator;
    logic [15:0] car_sources;

    assign mod_eff = enable_q ? mod_sel_q : `DSM_MOD_SWBIT;
    assign hi_eff  = enable_q ? hi_sel_q  : `DSM_CAR_GROUND;
    assign lo_eff  = enable_q ? lo_sel_q  : `DSM_CAR_GROUND;

    // Code 0 is ground; code 9 is dropped inside each carrier channel
    assign car_sources = {car_periph_s, pins_s[2], pins_s[1], 1'b0};

    always_comb begin
        case (mod_eff)
            `DSM_MOD_SWBIT: begin
                modulator = sw_bit_q;
            end
            `DSM_MOD_PIN: begin
                modulator = pins_s[0];
            end
            default: begin
                modulator = mod_periph_s[mod_eff];
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Carrier channels and mixing
    logic carrier_hi;
    logic carrier_lo;
    logic hi_active;
    logic lo_active;
    logic mixed;
    logic hi_gated;
    logic lo_gated;
    logic out_d;

    dsm_carrier u_car_hi (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .code_i    (hi_eff),
        .invert_i  (hi_inv_q),
        .sync_en_i (hi_sync_q),
        .wanted_i  (modulator),
        .sources_i (car_sources),
        .carrier_o (carrier_hi),
        .active_o  (hi_active)
    );

    dsm_carrier u_car_lo (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .code_i    (lo_eff),
        .invert_i  (lo_inv_q),
        .sync_en_i (lo_sync_q),
        .wanted_i  (~modulator),
        .sources_i (car_sources),
        .carrier_o (carrier_lo),
        .active_o  (lo_active)
    );

    // Each carrier passes only while its channel is active
    assign hi_gated = hi_active & carrier_hi;
    assign lo_gated = lo_active & carrier_lo;

    // Sampled at 25 MHz: faster sources alias, a known limitation
    assign mixed = hi_gated | lo_gated;

    // Disabled output is forced low even with the invert bit set
    assign out_d = enable_q ? (mixed ^ out_inv_q) : 1'b0;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            out_q <= 1'b0;
        end else begin
            out_q <= out_d;
        end
    end

    assign mod_out_o = out_q;
endmodule : dsm_top

// [dsm_consts.svh]
`ifndef DSM_CONSTS_SVH
`define DSM_CONSTS_SVH

// Register byte addresses on the APB
`define DSM_ADDR_CTRL       12'h000
`define DSM_ADDR_SRC        12'h004
`define DSM_ADDR_CARRIER_HIGH       12'h008
`define DSM_ADDR_CARRIER_LOW       12'h00c

// modulation_control fields
`define DSM_CTRL_EN_BIT     7
`define DSM_CTRL_OINV_BIT   4
`define DSM_CTRL_OUT_BIT    3
`define DSM_CTRL_SWBIT_BIT  0

// Carrier register fields
`define DSM_CAR_INV_BIT     6
`define DSM_CAR_SYNC_BIT    5
`define DSM_FIELD_MSB       3

// Reset values
`define DSM_CTRL_RESET      8'h00
`define DSM_SRC_RESET       4'h0
`define DSM_CAR_RESET       4'h0

// Source codes
`define DSM_MOD_SWBIT       4'h0
`define DSM_MOD_PIN         4'h1
`define DSM_CAR_GROUND      4'h0
`define DSM_CAR_PIN_A       4'h1
`define DSM_CAR_PIN_B       4'h2
`define DSM_CAR_RESERVED    4'h9

`endif

// [dsm_pkg.sv]
package dsm_pkg;
    typedef logic [3:0] dsm_code_t;
    typedef logic [7:0] dsm_byte_t;
endpackage : dsm_pkg

// [dsm_sync2.sv]
`timescale 1ns/100ps
module dsm_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : dsm_sync2

// [dsm_carrier.sv]
`timescale 1ns/100ps
`include "dsm_consts.svh"
module dsm_carrier
    import dsm_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire dsm_code_t   code_i,
    input  wire logic        invert_i,
    input  wire logic        sync_en_i,
    input  wire logic        wanted_i,
    input  wire logic [15:0] sources_i,
    output logic             carrier_o,
    output logic             active_o
);
    logic raw;
    logic car_prev_q;
    logic act_q;
    logic fall;

    always_comb begin
        if (code_i == `DSM_CAR_GROUND || code_i == `DSM_CAR_RESERVED) begin
            raw = 1'b0;
        end else begin
            raw = sources_i[code_i];
        end
    end

    assign carrier_o = raw ^ invert_i;
    assign fall      = car_prev_q & ~carrier_o;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            car_prev_q <= 1'b0;
        end else begin
            car_prev_q <= carrier_o;
        end
    end

    // Synced carrier changes its activity only at its own falling edge
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            act_q <= 1'b0;
        end else if (!sync_en_i || fall) begin
            act_q <= wanted_i;
        end
    end

    assign active_o = sync_en_i ? act_q : wanted_i;
endmodule : dsm_carrier

// [dsm_chk_properties.sv]
`timescale 1ns/100ps
module dsm_chk (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        mod_out_o
);
    logic en_q;
    wire  rd = pready_o && !pwrite_i;
    wire  ok = paddr_i <= 12'h00c && paddr_i[1:0] == 2'h0;
    // Enable shadow, rebuilt from bus writes since internals are hidden
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            en_q <= 1'b0;
        end else if (pready_o && pwrite_i && paddr_i == 12'h000) begin
            en_q <= pwdata_i[7];
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    rdy_access_a: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access");
    rdy_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready too long");
    one_wait_a: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
        else $error("wait state wrong");
    err_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    bad_addr_a: assert property (pready_o && !ok |-> pslverr_o && (pwrite_i || !prdata_o))
        else $error("unmapped not refused");
    good_addr_a: assert property (pready_o && ok |-> !pslverr_o)
        else $error("mapped refused");
    ctrl_resv_a: assert property (rd && paddr_i == 12'h000 |-> !(prdata_o & 32'h66))
        else $error("control spare bits set");
    car_resv_a: assert property (rd && ok && paddr_i[3] |-> !(prdata_o & 32'h90))
        else $error("carrier spare bits set");
    off_low_a: assert property (!en_q [*3] |-> !mod_out_o)
        else $error("output high while off");
    cover property (pready_o && pslverr_o);
    cover property (en_q && $rose(mod_out_o));
    cover property (en_q && $fell(mod_out_o));
endmodule : dsm_chk

bind dsm_top dsm_chk CHK (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .mod_out_o);

// [dsm_sources.sv]
`timescale 1ns/100ps
module dsm_sources (
    input  wire logic        mclk_i,
    output logic             mod_pin_o,
    output logic      [15:2] mod_periph_o,
    output logic             pin_a_o,
    output logic             pin_b_o,
    output logic      [15:3] car_periph_o
);
    initial {mod_pin_o, mod_periph_o, pin_a_o, pin_b_o, car_periph_o} = '0;
    // Moves only after an edge, so results never hinge on sampling races
    task automatic set(input logic m, a, b, input logic [15:2] mp, input logic [15:3] cp);
        @(posedge mclk_i);
        mod_pin_o <= m;
        mod_periph_o <= mp;
        pin_a_o <= a;
        pin_b_o <= b;
        car_periph_o <= cp;
    endtask : set
endmodule : dsm_sources

// [dsm_top_test.sv]
`timescale 1ns/100ps
`include "dsm_consts.svh"
module dsm_top_test;
    localparam logic [11:0] CT = `DSM_ADDR_CTRL;
    localparam logic [11:0] SR = `DSM_ADDR_SRC;
    localparam logic [11:0] CH = `DSM_ADDR_CARRIER_HIGH;
    localparam logic [11:0] CL = `DSM_ADDR_CARRIER_LOW;
    logic        mclk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
    logic        mod_out_o, mod_input_pin_i, carrier_input_pin_a_i, carrier_input_pin_b_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rdv;
    logic [15:2] mod_periph_i;
    logic [15:3] car_periph_i;
    logic [15:0] oh;
    logic [3:0]  sq [10] = '{4'h5, 4'h0, 4'h4, 4'hc, 4'h8, 4'hd, 4'h2, 4'h0, 4'h3, 4'hb};
    int          err_total, comparisons, i, k;

    dsm_top DUT (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .mod_input_pin_i, .mod_periph_i,
        .carrier_input_pin_a_i, .carrier_input_pin_b_i, .car_periph_i, .mod_out_o);
    dsm_sources SRC (.mclk_i, .mod_pin_o(mod_input_pin_i), .mod_periph_o(mod_periph_i),
        .pin_a_o(carrier_input_pin_a_i), .pin_b_o(carrier_input_pin_b_i),
        .car_periph_o(car_periph_i));

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Holds the request until ready; one idle edge keeps drives single per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        rdv = prdata_o;
        e = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
        if (n >= 16) begin
            err_total++;
            conclude();
        end
        @(posedge mclk_i);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("prdata", rdv, x);
    endtask : rd
    // Covers the two-edge source latency plus the register hop, with one edge spare
    task automatic oc(input logic x);
        repeat (4) @(posedge mclk_i);
        chk("mod_out", 32'(mod_out_o), 32'(x));
    endtask : oc
    ////////////////////////////////////////////////////////////////////////
    initial begin
        err_total = 0;
        comparisons = 0;
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        rst_i = 1'b1;
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        for (i = 0; i < 4; i++) rd(12'(i * 4), 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("pslverr", 32'(e), 32'h1);
        for (i = 1; i < 4; i++) begin
            wr(12'(i * 4), 32'hff);
            rd(12'(i * 4), (i == 1) ? 32'h0f : 32'h6f);
            wr(12'(i * 4), 32'h0);
        end
        wr(CT, 32'hff);
        oc(1'b1);
        rd(CT, 32'h99);
        wr(CT, 32'h10);
        oc(1'b0);
        wr(SR, 32'h1);
        for (i = 0; i < 64; i++) begin
            SRC.set(i[0], i[1], i[2], '0, '0);
            wr(CH, {25'h0, i[3], 6'h01});
            wr(CL, {25'h0, i[4], 6'h02});
            wr(CT, {24'h0, 3'h4, i[5], 4'h0});
            oc((i[0] ? i[1] ^ i[3] : i[2] ^ i[4]) ^ i[5]);
        end
        wr(CT, 32'h10);
        oc(1'b0);
        rd(CH, 32'h41);
        wr(CT, 32'h90);
        oc(1'b1);
        wr(SR, 32'h0);
        wr(CL, 32'h0);
        wr(CH, 32'h01);
        wr(CT, 32'h81);
        oc(1'b1);
        wr(CT, 32'h80);
        oc(1'b0);
        for (k = 0; k < 16; k++) begin
            oh = 16'h1 << k;
            wr(SR, 32'(k));
            SRC.set(k == 1, 1'b1, 1'b0, oh[15:2], '0);
            oc(k != 0);
            SRC.set(k != 1, 1'b1, 1'b0, ~oh[15:2], '0);
            oc(1'b0);
        end
        wr(SR, 32'h1);
        for (k = 0; k < 16; k++) begin
            oh = 16'h1 << k;
            wr(CH, 32'(k));
            SRC.set(1'b1, k == 1, k == 2, '0, oh[15:3]);
            oc(k != 0 && k != 9);
            SRC.set(1'b1, k != 1, k != 2, '0, ~oh[15:3]);
            oc(1'b0);
        end
        wr(CH, 32'h21);
        for (i = 0; i < 10; i++) begin
            if (i == 6) begin
                wr(CH, 32'h01);
                wr(CL, 32'h22);
            end
            SRC.set(sq[i][3], sq[i][2], sq[i][1], '0, '0);
            oc(sq[i][0]);
        end
        // Second reset over a live configuration must restore every default
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        oc(1'b0);
        for (i = 0; i < 4; i++) rd(12'(i * 4), 32'h0);
        conclude();
    end
endmodule : dsm_top_test
